// ---- fts_supervisor.sv ----
// Purpose: Threshold supervisor, status latch and fault response engine.
// Assumes: Measurements come from logic on the same clock.
// Notes: Straps are pins and are synchronised before capture.
`timescale 1ns/1ps
module fts_supervisor #(
   parameter int RETRY_COUNT = fts_pkg::RETRY_CYCLES
) (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_in,
   // Command port.
   input wire logic cmd_write_in,
   input wire logic cmd_read_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [15:0] cmd_wdata_in,
   output logic [15:0] cmd_rdata_out,
   output logic cmd_rvalid_out,
   // Pin straps.
   input wire logic [15:0] strap_vout_nominal_in,
   input wire logic [15:0] strap_vin_uv_fault_in,
   // Measurement path.
   input wire logic meas_valid_in,
   input wire logic [15:0] meas_vout_in,
   input wire logic [15:0] meas_vin_in,
   input wire logic [15:0] meas_temp_in,
   input wire logic [15:0] meas_sense_in,
   input wire logic ramping_in,
   // Control and indication.
   output logic output_enable_out,
   output logic retry_attempt_out,
   output logic power_good_out,
   output logic alert_out,
   output logic signed [31:0] iout_report_out,
   output logic signed [31:0] peak_limit_out,
   output logic signed [31:0] valley_limit_out,
   output fts_pkg::fts_status_s status_out
);
   import fts_pkg::*;

   fts_state_s state_reg;
   fts_state_s state_next;

   function automatic logic [15:0] reset_value(input int ix);
      unique case (ix)
         IX_GAIN: reset_value = GAIN_RESET;
         IX_OFFS: reset_value = OFFS_RESET;
         IX_VOVF_ACT, IX_VUVF_ACT, IX_OTF_ACT, IX_UTF_ACT, IX_VINOVF_ACT,
         IX_VINUVF_ACT: reset_value = {8'h00, ACT_DISABLE};
         IX_OC: reset_value = OC_RESET;
         IX_UC: reset_value = UC_RESET;
         IX_OTF: reset_value = OTF_RESET;
         IX_OTW: reset_value = OTW_RESET;
         IX_UTW: reset_value = UTW_RESET;
         IX_UTF: reset_value = UTF_RESET;
         IX_VINOVF: reset_value = VINOVF_RESET;
         IX_VINOVW: reset_value = VINOVW_RESET;
         default: reset_value = STRAPPED_RESET;
      endcase
   endfunction

   function automatic logic is_action(input int ix);
      is_action = (ix == IX_VOVF_ACT) || (ix == IX_VUVF_ACT) ||
                  (ix == IX_OTF_ACT) || (ix == IX_UTF_ACT) ||
                  (ix == IX_VINOVF_ACT) || (ix == IX_VINUVF_ACT);
   endfunction

   logic [NUM_REGS-1:0][15:0] regs_reset;
   logic [NUM_REGS-1:0] code_hit;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_regs
         assign regs_reset[gi] = reset_value(gi);
         assign code_hit[gi] = (cmd_code_in == REG_CODES[gi]);
      end
   endgenerate

   // Scaled values of calibration and threshold words and measurements.
   logic signed [63:0] temp_fix;
   logic signed [63:0] vin_fix;
   logic signed [63:0] sense_fix;
   logic signed [63:0] gain_fix;
   logic signed [63:0] offs_fix;
   logic signed [63:0] oc_fix;
   logic signed [63:0] uc_fix;
   logic signed [63:0] iout_fix;
   fts_status_s eval;
   logic ov_fault;
   logic uv_fault;
   logic ot_fault;
   logic ut_fault;
   logic vinov_fault;
   logic vinuv_fault;
   logic pg_hold_eval;
   logic any_fault;
   logic latch_any;
   logic retry_due;

   always_comb begin
      state_next = state_reg;
      state_next.retry_pulse = 1'b0;
      state_next.rvalid = 1'b0;

      // Straps pass two flip-flops, then load the strapped thresholds.
      state_next.vnom_s1 = strap_vout_nominal_in;
      state_next.vnom_s2 = state_reg.vnom_s1;
      state_next.vinuv_s1 = strap_vin_uv_fault_in;
      state_next.vinuv_s2 = state_reg.vinuv_s1;
      if (state_reg.strap_cnt != 2'(STRAP_SETTLE)) begin
         state_next.strap_cnt = state_reg.strap_cnt + 2'd1;
      end
      if (state_reg.strap_cnt == 2'(STRAP_SETTLE - 1)) begin
         state_next.regs[IX_VOVF] =
            pct_l16(state_reg.vnom_s2, PCT_VOVF);
         state_next.regs[IX_VOVW] = pct_l16(state_reg.vnom_s2, PCT_VOVW);
         state_next.regs[IX_VUVW] = pct_l16(state_reg.vnom_s2, PCT_VUVW);
         state_next.regs[IX_VUVF] = pct_l16(state_reg.vnom_s2, PCT_VUVF);
         state_next.regs[IX_PGON] = pct_l16(state_reg.vnom_s2, PCT_PGON);
         state_next.regs[IX_VINUVF] = state_reg.vinuv_s2;
         state_next.regs[IX_VINUVW] = {state_reg.vinuv_s2[15:11], 11'(
            pct_l16({5'h00, state_reg.vinuv_s2[10:0]}, PCT_VINUVW))};
      end

      // Register writes; actions take only the two legal codes.
      for (int i = 0; i < NUM_REGS; i++) begin
         if (cmd_write_in && code_hit[i]) begin
            if (!is_action(i)) begin
               state_next.regs[i] = cmd_wdata_in;
            end else if (cmd_wdata_in[7:0] == ACT_DISABLE ||
                         cmd_wdata_in[7:0] == ACT_RETRY) begin
               state_next.regs[i] = {8'h00, cmd_wdata_in[7:0]};
            end
         end
      end

      // Register reads answer one cycle later.
      if (cmd_read_in) begin
         state_next.rvalid = 1'b1;
         state_next.rdata = 16'h0000;
         for (int i = 0; i < NUM_REGS; i++) begin
            if (code_hit[i]) begin
               state_next.rdata = state_reg.regs[i];
            end
         end
         unique case (cmd_code_in)
            CODE_STATUS_BYTE, CODE_STATUS_WORD: begin
               state_next.rdata = {state_reg.status.vout != 8'h00,
                  state_reg.status.iout != 8'h00,
                  state_reg.status.input_v != 8'h00, 1'b0,
                  !state_reg.power_good, 3'b000, 1'b0,
                  !state_reg.enable, state_reg.status.vout[7],
                  state_reg.status.iout[7], state_reg.status.input_v[4],
                  state_reg.status.temp != 8'h00, 1'b0,
                  state_reg.status.input_v[6:5] != 2'b00};
               if (cmd_code_in == CODE_STATUS_BYTE) begin
                  state_next.rdata[15:8] = 8'h00;
               end
            end
            CODE_STATUS_VOUT:
               state_next.rdata = {8'h00, state_reg.status.vout};
            CODE_STATUS_IOUT:
               state_next.rdata = {8'h00, state_reg.status.iout};
            CODE_STATUS_INPUT: begin
               state_next.rdata = {8'h00, state_reg.status.input_v};
            end
            CODE_STATUS_TEMP:
               state_next.rdata = {8'h00, state_reg.status.temp};
            default: begin
            end
         endcase
      end

      // Conditions are evaluated once per measurement update.
      temp_fix = l11_fix(meas_temp_in);
      vin_fix = l11_fix(meas_vin_in);
      sense_fix = l11_fix(meas_sense_in);
      gain_fix = l11_fix(state_reg.regs[IX_GAIN]);
      offs_fix = l11_fix(state_reg.regs[IX_OFFS]);
      oc_fix = l11_fix(state_reg.regs[IX_OC]);
      uc_fix = l11_fix(state_reg.regs[IX_UC]);
      iout_fix = offs_fix;
      if (gain_fix != 64'sd0) begin
         iout_fix = ((sense_fix <<< FIX_FRAC_BITS) / gain_fix) +
                    offs_fix;
      end

      // Output voltage words share one exponent, so they compare directly.
      ov_fault = meas_vout_in > state_reg.regs[IX_VOVF];
      uv_fault = (meas_vout_in < state_reg.regs[IX_VUVF]) &&
                 !ramping_in && state_reg.enable;
      ot_fault = (temp_fix > l11_fix(state_reg.regs[IX_OTF])) ||
                 (state_reg.ot_hold &&
                  !(temp_fix < l11_fix(state_reg.regs[IX_OTW])));
      ut_fault = (temp_fix < l11_fix(state_reg.regs[IX_UTF])) ||
                 (state_reg.ut_hold &&
                  !(temp_fix > l11_fix(state_reg.regs[IX_UTW])));
      vinov_fault = vin_fix > l11_fix(state_reg.regs[IX_VINOVF]);
      vinuv_fault = (vin_fix < l11_fix(state_reg.regs[IX_VINUVF])) ||
                    (state_reg.vinuv_hold &&
                     !(vin_fix > l11_fix(state_reg.regs[IX_VINUVW])));
      pg_hold_eval = (meas_vout_in > state_reg.regs[IX_PGON]) ||
                     (state_reg.pg_hold &&
                      !(meas_vout_in < state_reg.regs[IX_VUVF]));

      eval = '0;
      eval.vout[7] = ov_fault;
      eval.vout[6] = meas_vout_in > state_reg.regs[IX_VOVW];
      eval.vout[5] = meas_vout_in < state_reg.regs[IX_VUVW];
      eval.vout[4] = uv_fault;
      eval.iout[7] = iout_fix > oc_fix;
      eval.iout[4] = iout_fix < uc_fix;
      eval.temp[7] = ot_fault;
      eval.temp[6] = temp_fix > l11_fix(state_reg.regs[IX_OTW]);
      eval.temp[5] = temp_fix < l11_fix(state_reg.regs[IX_UTW]);
      eval.temp[4] = ut_fault;
      eval.input_v[7] = vinov_fault;
      eval.input_v[6] = vin_fix > l11_fix(state_reg.regs[IX_VINOVW]);
      eval.input_v[5] = vin_fix < l11_fix(state_reg.regs[IX_VINUVW]);
      eval.input_v[4] = vinuv_fault;

      if (meas_valid_in) begin
         state_next.cond = eval;
         state_next.ot_hold = ot_fault;
         state_next.ut_hold = ut_fault;
         state_next.vinuv_hold = vinuv_fault;
         state_next.pg_hold = pg_hold_eval;
         state_next.power_good = pg_hold_eval && !eval.vout[6] &&
                                 !eval.vout[5] && state_reg.enable;
         state_next.iout_rep = 32'(iout_fix);
         state_next.peak_lim = 32'(oc_fix) + RIPPLE_HALF_FIX;
         state_next.valley_lim = 32'(uc_fix) - RIPPLE_HALF_FIX;
      end
      if (!state_reg.enable) begin
         state_next.power_good = 1'b0;
      end

      // Status latches; a new condition wins over a clear in that cycle.
      if (cmd_write_in && cmd_code_in == CODE_CLEAR_FAULTS) begin
         state_next.status = state_next.cond;
         state_next.alert = state_next.cond != '0;
      end else if (meas_valid_in) begin
         state_next.status = state_reg.status | eval;
         if ((eval & ~state_reg.status) != '0) begin
            state_next.alert = 1'b1;
         end
      end

      // Fault response engine.
      any_fault = (state_next.cond.vout[7] | state_next.cond.vout[4] |
                   state_next.cond.temp[7] | state_next.cond.temp[4] |
                   state_next.cond.input_v[7] | state_next.cond.input_v[4]);
      latch_any =
         (state_next.cond.vout[7] &&
          state_reg.regs[IX_VOVF_ACT][7:0] != ACT_RETRY) ||
         (state_next.cond.vout[4] &&
          state_reg.regs[IX_VUVF_ACT][7:0] != ACT_RETRY) ||
         (state_next.cond.temp[7] &&
          state_reg.regs[IX_OTF_ACT][7:0] != ACT_RETRY) ||
         (state_next.cond.temp[4] &&
          state_reg.regs[IX_UTF_ACT][7:0] != ACT_RETRY) ||
         (state_next.cond.input_v[7] &&
          state_reg.regs[IX_VINOVF_ACT][7:0] != ACT_RETRY) ||
         (state_next.cond.input_v[4] &&
          state_reg.regs[IX_VINUVF_ACT][7:0] != ACT_RETRY);
      retry_due = state_reg.retry_cnt >= 32'(RETRY_COUNT - 1);
      if (!retry_due) begin
         state_next.retry_cnt = state_reg.retry_cnt + 32'd1;
      end

      unique case (state_reg.resp)
         FTS_RUN: begin
            if (any_fault) begin
               state_next.enable = 1'b0;
               state_next.resp = latch_any ? FTS_LATCHED : FTS_RETRY_WAIT;
            end
         end
         FTS_RETRY_WAIT: begin
            if (latch_any) begin
               state_next.resp = FTS_LATCHED;
            end else if (retry_due) begin
               state_next.retry_cnt = 32'd0;
               state_next.retry_pulse = 1'b1;
               if (!any_fault) begin
                  state_next.enable = 1'b1;
                  state_next.resp = FTS_RUN;
               end
            end
         end
         FTS_LATCHED: begin
            state_next.enable = 1'b0;
         end
         default: begin
            state_next.resp = FTS_LATCHED;
            state_next.enable = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         state_reg <= '0;
         state_reg.regs <= regs_reset;
         state_reg.enable <= 1'b1;
         state_reg.resp <= FTS_RUN;
         state_reg.retry_cnt <= 32'(RETRY_COUNT - 1);
      end else begin
         state_reg <= state_next;
      end
   end

   assign cmd_rdata_out = state_reg.rdata;
   assign cmd_rvalid_out = state_reg.rvalid;
   assign output_enable_out = state_reg.enable;
   assign retry_attempt_out = state_reg.retry_pulse;
   assign power_good_out = state_reg.power_good;
   assign alert_out = state_reg.alert;
   assign iout_report_out = state_reg.iout_rep;
   assign peak_limit_out = state_reg.peak_lim;
   assign valley_limit_out = state_reg.valley_lim;
   assign status_out = state_reg.status;

endmodule // fts_supervisor

// ---- fts_pkg.sv ----
// Purpose: Shared constants, types and decoders of the fault supervisor.
// Assumes: Ten megahertz clock; words arrive already assembled.
// Notes: Fixed-point values carry sixteen fraction bits.
package fts_pkg;

   localparam int NUM_REGS = 23;
   localparam int CLK_PERIOD_NS = 100;
   localparam int RETRY_DELAY_NS = 70_000_000;
   localparam int RETRY_CYCLES = RETRY_DELAY_NS / CLK_PERIOD_NS;
   localparam int FIX_FRAC_BITS = 16;
   localparam int STRAP_SETTLE = 3;

   // Command codes of the calibration words, thresholds and actions, in table order.
   localparam logic [NUM_REGS-1:0][7:0] REG_CODES = {
      8'h5e, 8'h5a, 8'h59, 8'h58, 8'h57, 8'h56, 8'h55, 8'h54,
      8'h53, 8'h52, 8'h51, 8'h50, 8'h4f, 8'h4b, 8'h46, 8'h45,
      8'h44, 8'h43, 8'h42, 8'h41, 8'h40, 8'h39, 8'h38};
   localparam int IX_GAIN = 0, IX_OFFS = 1, IX_VOVF = 2, IX_VOVF_ACT = 3;
   localparam int IX_VOVW = 4, IX_VUVW = 5, IX_VUVF = 6, IX_VUVF_ACT = 7;
   localparam int IX_OC = 8, IX_UC = 9, IX_OTF = 10, IX_OTF_ACT = 11;
   localparam int IX_OTW = 12, IX_UTW = 13, IX_UTF = 14, IX_UTF_ACT = 15;
   localparam int IX_VINOVF = 16, IX_VINOVF_ACT = 17, IX_VINOVW = 18;
   localparam int IX_VINUVW = 19, IX_VINUVF = 20, IX_VINUVF_ACT = 21;
   localparam int IX_PGON = 22;

   localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CODE_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CODE_STATUS_WORD = 8'h79;
   localparam logic [7:0] CODE_STATUS_VOUT = 8'h7a;
   localparam logic [7:0] CODE_STATUS_IOUT = 8'h7b;
   localparam logic [7:0] CODE_STATUS_INPUT = 8'h7c;
   localparam logic [7:0] CODE_STATUS_TEMP = 8'h7d;

   localparam logic [7:0] ACT_DISABLE = 8'h80;
   localparam logic [7:0] ACT_RETRY = 8'hbf;
   localparam logic [15:0] OC_RESET = 16'he280;
   localparam logic [15:0] UC_RESET = {OC_RESET[15:11], 11'(-OC_RESET[10:0])};
   localparam logic [15:0] GAIN_RESET = 16'hb2ae;
   localparam logic [15:0] OFFS_RESET = 16'h0000;
   localparam logic [15:0] OTF_RESET = 16'hebe8;
   localparam logic [15:0] OTW_RESET = 16'heb70;
   localparam logic [15:0] UTW_RESET = 16'hdc40;
   localparam logic [15:0] UTF_RESET = 16'he530;
   localparam logic [15:0] VINOVF_RESET = 16'hd380;
   localparam logic [15:0] VINOVW_RESET = 16'hd327;
   localparam logic [15:0] STRAPPED_RESET = 16'h0000;

   // Pin-strap scale factors in percent.
   localparam int PCT_VOVF = 115, PCT_VOVW = 85, PCT_VUVW = 85;
   localparam int PCT_VUVF = 85, PCT_PGON = 90, PCT_VINUVW = 110;
   localparam int PCT_UNIT = 100;

   // Half inductor ripple used to derive peak and valley limits.
   localparam logic signed [31:0] RIPPLE_HALF_FIX = 32'sh0005_0000;

   typedef enum logic [1:0] {
      FTS_RUN = 2'b00,
      FTS_LATCHED = 2'b01,
      FTS_RETRY_WAIT = 2'b10
   } fts_resp_e;

   typedef struct packed {
      logic [7:0] vout;
      logic [7:0] iout;
      logic [7:0] temp;
      logic [7:0] input_v;
   } fts_status_s;

   typedef struct packed {
      logic [NUM_REGS-1:0][15:0] regs;
      logic [1:0] strap_cnt;
      logic [15:0] vnom_s1;
      logic [15:0] vnom_s2;
      logic [15:0] vinuv_s1;
      logic [15:0] vinuv_s2;
      fts_status_s cond;
      fts_status_s status;
      logic ot_hold;
      logic ut_hold;
      logic vinuv_hold;
      logic pg_hold;
      logic power_good;
      logic enable;
      fts_resp_e resp;
      logic [31:0] retry_cnt;
      logic retry_pulse;
      logic alert;
      logic [15:0] rdata;
      logic rvalid;
      logic signed [31:0] iout_rep;
      logic signed [31:0] peak_lim;
      logic signed [31:0] valley_lim;
   } fts_state_s;

   // Sign-extended exponent and mantissa scaled to sixteen fraction bits.
   function automatic logic signed [63:0] l11_fix(input logic [15:0] w);
      logic signed [4:0] e;
      logic signed [63:0] m;
      int sh;
      e = signed'(w[15:11]);
      m = 64'(signed'(w[10:0]));
      sh = int'(e) + FIX_FRAC_BITS;
      l11_fix = m <<< sh;
   endfunction

   function automatic logic [15:0] pct_l16(input logic [15:0] w,
                                           input int pct);
      pct_l16 = 16'((32'(w) * 32'(pct)) / 32'(PCT_UNIT));
   endfunction

endpackage

// ---- fts_supervisor_checker.sv ----
// Purpose: Port-level checks of the fault supervisor.
// Assumes: One clock domain with synchronous active-high reset.
// Notes: Bound onto every supervisor instance.
`timescale 1ns/1ps
module fts_supervisor_checker #(
   parameter int RETRY_COUNT = 20
) (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_in,
   // Watched inputs.
   input wire logic cmd_write_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic meas_valid_in,
   input wire logic ramping_in,
   // Watched outputs.
   input wire logic output_enable_out,
   input wire logic retry_attempt_out,
   input wire logic power_good_out,
   input wire logic alert_out,
   input wire fts_pkg::fts_status_s status_out
);
   import fts_pkg::*;
   int unsigned gap_cnt;
   logic off_run;
   logic clr;
   assign clr = cmd_write_in && cmd_code_in == CODE_CLEAR_FAULTS;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);
   // Counts cycles since the last attempt and tracks whether the output has stayed off since then.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         gap_cnt <= 0;
         off_run <= 1'b0;
      end else if (retry_attempt_out) begin
         gap_cnt <= 1;
         off_run <= 1'b1;
      end else begin
         gap_cnt <= (gap_cnt < 1000000) ? gap_cnt + 1 : gap_cnt;
         off_run <= off_run && !output_enable_out;
      end
   end
   property p_retry_gap;
      retry_attempt_out && off_run |-> gap_cnt == RETRY_COUNT;
   endproperty
   a_retry_gap: assert property (p_retry_gap)
      else $error("retry spacing wrong");
   property p_enable_rise;
      $rose(output_enable_out) |->
         retry_attempt_out || $past(retry_attempt_out);
   endproperty
   a_enable_rise: assert property (p_enable_rise)
      else $error("output restarted without an attempt");
   property p_ov_off;
      $rose(status_out.vout[7]) |-> !output_enable_out;
   endproperty
   a_ov_off: assert property (p_ov_off)
      else $error("overvoltage fault left output on");
   property p_pg_meas;
      $rose(power_good_out) |-> $past(meas_valid_in);
   endproperty
   a_pg_meas: assert property (p_pg_meas)
      else $error("power good rose without a measurement");
   property p_pg_off;
      !output_enable_out && !$past(output_enable_out) |-> !power_good_out;
   endproperty
   a_pg_off: assert property (p_pg_off)
      else $error("power good high while disabled");
   property p_uv_mask;
      meas_valid_in && (ramping_in || !output_enable_out) |=>
         !$rose(status_out.vout[4]);
   endproperty
   a_uv_mask: assert property (p_uv_mask)
      else $error("masked undervoltage fault set");
   property p_sticky;
      |($past(status_out) & ~status_out) |-> $past(clr);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("status bit dropped without clear");
   property p_ot_warn;
      $rose(status_out.temp[6]) |-> $past(meas_valid_in) && alert_out;
   endproperty
   a_ot_warn: assert property (p_ot_warn)
      else $error("over-temperature warning without alert");
   property p_ut_warn;
      $rose(status_out.temp[5]) |-> $past(meas_valid_in) && alert_out;
   endproperty
   a_ut_warn: assert property (p_ut_warn)
      else $error("under-temperature warning without alert");
   property p_alert;
      status_out != '0 |-> alert_out;
   endproperty
   a_alert: assert property (p_alert)
      else $error("status set but alert low");
   c_retry: cover property (retry_attempt_out && off_run);
   c_pg: cover property ($rose(power_good_out));
   c_clr: cover property (clr && alert_out);
endmodule // fts_supervisor_checker

bind fts_supervisor fts_supervisor_checker #(.RETRY_COUNT(RETRY_COUNT))
   fts_supervisor_checker_inst (.clock_in, .reset_in, .cmd_write_in,
   .cmd_code_in, .meas_valid_in, .ramping_in, .output_enable_out,
   .retry_attempt_out, .power_good_out, .alert_out, .status_out);

// ---- fts_host.sv ----
// Purpose: Host side of the command port.
// Assumes: Strobes last one cycle; read answer one cycle later.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/1ps
module fts_host (
   // Clock.
   input wire logic clock_in,
   // Command port.
   output logic cmd_write_out,
   output logic cmd_read_out,
   output logic [7:0] cmd_code_out,
   output logic [15:0] cmd_wdata_out,
   input wire logic [15:0] cmd_rdata_in,
   input wire logic cmd_rvalid_in
);
   initial begin
      cmd_write_out = 1'b0;
      cmd_read_out = 1'b0;
      cmd_code_out = 8'h00;
      cmd_wdata_out = 16'h0000;
   end
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clock_in);
      cmd_write_out <= 1'b1;
      cmd_code_out <= c;
      cmd_wdata_out <= d;
      @(posedge clock_in);
      cmd_write_out <= 1'b0;
      cmd_code_out <= ~c;
      cmd_wdata_out <= ~d;
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d,
                     output logic ok);
      int n;
      @(posedge clock_in);
      cmd_read_out <= 1'b1;
      cmd_code_out <= c;
      @(posedge clock_in);
      cmd_read_out <= 1'b0;
      cmd_code_out <= ~c;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (cmd_rvalid_in !== 1'b1 && n < 4);
      ok = cmd_rvalid_in;
      d = cmd_rdata_in;
   endtask
endmodule // fts_host

// ---- test_fault_threshold_supervisor.sv ----
// Purpose: Self-checking bench of the fault supervisor.
// Assumes: Retry count shortened to twenty cycles.
// Notes: Straps fixed at 1.0 V nominal and 9 V input fault.
`timescale 1ns/1ps
module test_fault_threshold_supervisor;
   import fts_pkg::*;
   localparam int RC = 20;
   localparam logic [15:0] VN = 16'h2000, VI = 16'hd300, TN = 16'hf064;
   logic clock_in, reset_in, cmd_write, cmd_read, cmd_rvalid, rok;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata, meas_vout, meas_vin, meas_temp, rdat;
   logic meas_valid, ramping, enable, retry, pgood, alert;
   fts_status_s status;
   logic [15:0] sense;
   logic signed [31:0] iout, peak, valley;
   int fails, compares;
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   fts_supervisor #(.RETRY_COUNT(RC)) fts_supervisor_inst (
      .clock_in(clock_in), .reset_in(reset_in),
      .cmd_write_in(cmd_write), .cmd_read_in(cmd_read),
      .cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata),
      .cmd_rdata_out(cmd_rdata), .cmd_rvalid_out(cmd_rvalid),
      .strap_vout_nominal_in(16'h2000), .strap_vin_uv_fault_in(16'hd240),
      .meas_valid_in(meas_valid), .meas_vout_in(meas_vout),
      .meas_vin_in(meas_vin), .meas_temp_in(meas_temp),
      .meas_sense_in(sense), .ramping_in(ramping),
      .output_enable_out(enable), .retry_attempt_out(retry),
      .power_good_out(pgood), .alert_out(alert), .iout_report_out(iout),
      .peak_limit_out(peak), .valley_limit_out(valley), .status_out(status));
   fts_host fts_host_inst (.clock_in(clock_in), .cmd_write_out(cmd_write),
      .cmd_read_out(cmd_read), .cmd_code_out(cmd_code),
      .cmd_wdata_out(cmd_wdata), .cmd_rdata_in(cmd_rdata),
      .cmd_rvalid_in(cmd_rvalid));
   task automatic complete_run();
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
      fts_host_inst.rd(c, rdat, rok);
      chk({rok, rdat}, {1'b1, e});
   endtask
   task automatic meas(input logic [15:0] vo, vi, te);
      @(posedge clock_in);
      meas_valid <= 1'b1;
      meas_vout <= vo;
      meas_vin <= vi;
      meas_temp <= te;
      @(posedge clock_in);
      meas_valid <= 1'b0;
      #10;
   endtask
   task automatic clr();
      fts_host_inst.wr(CODE_CLEAR_FAULTS, 16'h0000);
      #10;
   endtask
   task automatic next_pulse(output int n);
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (retry !== 1'b1 && n < 200);
      if (n >= 200) begin
         fails++;
         complete_run();
      end
   endtask
   task automatic s_regs();
      logic [23:0] t [19] = '{24'h38b2ae, 24'h390000, 24'h410080,
         24'h450080, 24'h46e280, 24'h4be580, 24'h4febe8, 24'h500080,
         24'h51eb70, 24'h52dc40, 24'h53e530, 24'h540080, 24'h55d380,
         24'h560080, 24'h57d327, 24'h5a0080, 24'h59d240, 24'h4024cc,
         24'h000000};
      foreach (t[i]) rdchk(t[i][23:16], t[i][15:0]);
      fts_host_inst.wr(8'h41, 16'h0055);
      rdchk(8'h41, 16'h0080);
      fts_host_inst.wr(8'h41, 16'h00bf);
      rdchk(8'h41, 16'h00bf);
      fts_host_inst.wr(8'h41, 16'h0080);
   endtask
   task automatic s_pgood();
      logic [23:0] t [5] = '{24'h402400, 24'h422200, 24'h431e00,
         24'h441c00, 24'h5e1f00};
      foreach (t[i]) fts_host_inst.wr(t[i][23:16], t[i][15:0]);
      rdchk(8'h42, 16'h2200);
      meas(VN, VI, TN);
      chk(pgood, 1'b1);
      meas(16'h2300, VI, TN);
      chk({pgood, status.vout}, {1'b0, 8'h40});
      meas(16'h1e80, VI, TN);
      chk(pgood, 1'b1);
      meas(VN, VI, TN);
      chk(pgood, 1'b1);
      meas(16'h1d00, VI, TN);
      chk({pgood, status.vout}, {1'b0, 8'h60});
      ramping <= 1'b1;
      meas(16'h1000, VI, TN);
      chk({enable, status.vout}, {1'b1, 8'h60});
      ramping <= 1'b0;
      clr();
      chk(status, 32'h2000_0000);
      meas(VN, VI, TN);
      clr();
      chk({alert, status}, 0);
   endtask
   task automatic s_warn();
      logic [15:0] vi [4] = '{VI, VI, 16'hd340, 16'hd260};
      logic [15:0] te [4] = '{16'hf1c0, 16'hf774, TN, TN};
      logic [31:0] st [4] = '{32'h4000, 32'h2000, 32'h40, 32'h20};
      logic [15:0] sw [4] = '{16'h0004, 16'h0004, 16'h2001, 16'h2001};
      fts_host_inst.wr(8'h58, 16'hd279);
      for (int i = 0; i < 4; i++) begin
         meas(VN, vi[i], te[i]);
         chk({alert, status}, {1'b1, st[i]});
         rdchk(CODE_STATUS_WORD, sw[i]);
         meas(VN, VI, TN);
         chk(status, st[i]);
         clr();
         chk({alert, status}, 0);
      end
   endtask
   task automatic s_retry();
      int n;
      fts_host_inst.wr(8'h56, 16'h00bf);
      meas(VN, 16'hd3c0, TN);
      chk({enable, status.input_v[7]}, 2'b01);
      next_pulse(n);
      next_pulse(n);
      chk(n, RC);
      chk(enable, 1'b0);
      meas(VN, VI, TN);
      next_pulse(n);
      repeat (2) @(posedge clock_in);
      #10;
      chk(enable, 1'b1);
      fts_host_inst.wr(8'h56, 16'h0080);
      clr();
   endtask
   task automatic s_ovfault();
      meas(16'h2500, VI, TN);
      chk({enable, pgood, status.vout[7]}, 3'b001);
      repeat (3 * RC) @(posedge clock_in);
      chk(enable, 1'b0);
   endtask
   task automatic s_current();
      sense <= 16'he2ae;
      meas(VN, VI, TN);
      chk({iout, status.iout}, 40'h0040_0000_80);
      chk({peak, valley}, 64'h002d_0000_ffd3_0000);
      sense <= 16'he552;
      meas(VN, VI, TN);
      chk({iout, status.iout}, 40'hffc0_0000_90);
   endtask
   initial begin
      fails = 0;
      compares = 0;
      reset_in = 1'b1;
      meas_valid = 1'b0;
      meas_vout = 16'h0000;
      meas_vin = 16'h0000;
      meas_temp = 16'h0000;
      ramping = 1'b0;
      sense = 16'h0000;
      repeat (16) @(posedge clock_in);
      reset_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      s_regs();
      s_pgood();
      s_warn();
      s_retry();
      s_ovfault();
      s_current();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clock_in);
      fails++;
      complete_run();
   end
endmodule // test_fault_threshold_supervisor
